// *** hdl/dfsp_pkg.sv ***
// Purpose: constants for the dual frame serial port
// Assumes: 16-bit register port, one clock
// Notes:   offsets are absolute 32-bit byte addresses
package dfsp_pkg;
	localparam int ADDR_W = 32;
	localparam logic [31:0] OFS_RXB_WORD = 32'h0FFFFA20;
	localparam logic [31:0] OFS_RXB_LOW  = 32'h0FFFFA22;
	localparam logic [31:0] OFS_FORMAT   = 32'hFFFFFA28;
	localparam logic [31:0] OFS_MODE     = 32'hFFFFFA2A;
	localparam logic [31:0] OFS_STATUS   = 32'hFFFFFA2C;
	localparam logic [31:0] OFS_TXS_WORD = 32'hFFFFFA30;
	localparam logic [31:0] OFS_TXS_LOW  = 32'hFFFFFA32;
	localparam logic [31:0] OFS_BAUD     = 32'hFFFFFA34;
	localparam logic [7:0]  FORMAT_RST   = 8'h81;
	localparam logic [7:0]  MODE_RST     = 8'h00;
	localparam logic [15:0] BAUD_RST     = 16'h000F;
	// format register fields
	localparam int F_RXE = 6;
	localparam int F_PS1 = 5;
	localparam int F_PS0 = 4;
	localparam int F_CL  = 3;
	localparam int F_SL  = 2;
	// mode register fields
	localparam int M_SYNC = 3;
	localparam int M_TX2  = 2;
	localparam int M_RX2  = 1;
	localparam int M_EBS  = 0;
	// status register fields
	localparam int S_TXB  = 7;
	localparam int S_RXB  = 6;
	localparam int S_RB8  = 4;
	localparam int S_PE   = 2;
	localparam int S_FE   = 1;
	localparam int S_OVE  = 0;
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] OVS_MID  = 4'h7;
	typedef enum logic [1:0] {
		DFSP_IDLE  = 2'b00,
		DFSP_START = 2'b01,
		DFSP_SHIFT = 2'b11,
		DFSP_STOP  = 2'b10
	} dfsp_state_t;
endpackage : dfsp_pkg

// *** hdl/dfsp_top.sv ***
// Purpose: second serial port, async or clocked, one- or two-frame transfer
// Assumes: baud divider gives a 16x oversample enable; sync mode uses it as bit clock
// Notes:   both interrupt outputs are one-cycle pulses
//
// Summary of operation
// R1 - mode bit 3 selects async or synchronous
// R2 - tx frame bit sends one or two frames
// R3 - rx frame bit completes on one or two
// R4 - extension bit adds a ninth data bit
// R5 - extension only with no parity, one frame
// R6 - software never sets extension with rx two-frame
// R7 - tx busy from write to last stop
// R8 - rx busy from start to stop detect
// R9 - ninth bit stored with the buffer
// R10 - parity error only for odd/even parity
// R11 - framing error when stop bit missing
// R12 - overrun when buffer unread, data overwritten
// R13 - errors show latest, cleared by buffer read
// R14 - overrun in two-frame mode delays interrupt
// R15 - unused buffer bits read zero; in 7-bit two-frame mode bit 15 takes the old shift register bit 7
// R16 - each frame moves to buffer, irq last
// R17 - receive disabled keeps buffer, no interrupt
// R18 - rx interrupt on last stop or error
// R19 - write to shift register starts transmit
// R20 - tx interrupt after all frames shifted
// R21 - rx interrupt has priority over tx
// R22 - start, data lsb first, parity, stops
// R23 - receiver idle while enable bit clear
// R24 - length bit picks seven or eight bits
// R25 - stop bit picks one or two stops
// R26 - start low, stop high, idle high
`timescale 1ns/10ps
module dfsp_top
	import dfsp_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic [dfsp_pkg::ADDR_W-1:0] ADDR,
	input  wire logic [15:0]       WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [15:0]       RDATA,
	input  wire logic              SERIAL_IN_PIN,
	output logic                   SERIAL_OUT_PIN,
	output logic                   RX_DONE_IRQ,
	output logic                   TX_DONE_IRQ,
	output logic      [1:0]        IRQ_PRIORITY
);
	import dfsp_pkg::*;

	logic [7:0]  fmt_r, mode_r;
	logic [15:0] baud_r, bcnt_r;
	logic [15:0] rdata_r;
	logic        tick;

	// address hits, shared by the write decode and the read mux
	wire hit_rxw  = ADDR == OFS_RXB_WORD;
	wire hit_rxl  = ADDR == OFS_RXB_LOW;
	wire hit_fmt  = ADDR == OFS_FORMAT;
	wire hit_mode = ADDR == OFS_MODE;
	wire hit_stat = ADDR == OFS_STATUS;
	wire hit_txw  = ADDR == OFS_TXS_WORD;
	wire hit_txl  = ADDR == OFS_TXS_LOW;
	wire hit_baud = ADDR == OFS_BAUD;

	// register decode
	wire w_fmt  = WR && hit_fmt;
	wire w_mode = WR && hit_mode;
	wire w_baud = WR && hit_baud;
	// either view of the shift register starts a transfer
	wire w_txs  = WR && (hit_txw || hit_txl);                        // [R19]
	wire w_low  = hit_txl;
	// either view of the buffer counts as read processing
	wire r_buf  = RD && (hit_rxw || hit_rxl);                        // [R13]

	wire rxe    = fmt_r[F_RXE];
	wire cl8    = fmt_r[F_CL];
	wire sl2    = fmt_r[F_SL];
	wire par_on = fmt_r[F_PS1] | fmt_r[F_PS0];
	wire par_ck = fmt_r[F_PS1];
	wire sync_m = mode_r[M_SYNC];                                   // [R1]
	wire tx2    = mode_r[M_TX2];
	wire rx2    = mode_r[M_RX2];
	wire ext    = mode_r[M_EBS] && !par_on && !tx2;                 // [R5] [R6]

	// data bits per frame: 7, 8 or 9
	wire [3:0] nbits = ext ? 4'h9 : (cl8 ? 4'h8 : 4'h7);           // [R4] [R24]

	function automatic logic par_bit(input logic [8:0] d, input logic [3:0] n,
		input logic [7:0] f);
		logic x;
		x = ^(d & ((9'h001 << n) - 9'h001));
		case ({f[F_PS1], f[F_PS0]})
			2'b10:   par_bit = ~x;
			2'b11:   par_bit = x;
			default: par_bit = 1'b0;
		endcase
	endfunction : par_bit

	// baud divider: 16x enable in async mode, bit enable in sync mode
	always_ff @(posedge CLK) begin
		if (!RST_N || bcnt_r == 16'h0000)
			bcnt_r <= baud_r;
		else
			bcnt_r <= bcnt_r - 16'h0001;
	end
	assign tick = (bcnt_r == 16'h0000);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			fmt_r  <= FORMAT_RST;
			mode_r <= MODE_RST;
			baud_r <= BAUD_RST;
		end else begin
			if (w_fmt)  fmt_r  <= WDATA[7:0];
			if (w_mode) mode_r <= {4'h0, WDATA[3:0]};
			if (w_baud) baud_r <= WDATA;
		end
	end

	// input synchroniser
	logic rx_s1_r, rx_s2_r;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
		end else begin
			rx_s1_r <= SERIAL_IN_PIN;
			rx_s2_r <= rx_s1_r;
		end
	end

	// ---------------- transmitter ----------------
	dfsp_state_t tx_st_r;
	logic [15:0] txd_r;
	logic [3:0]  tx_os_r, tx_bit_r;
	logic        tx_second_r, tx_busy_r, tx_par_r, tx_out_r, tx_irq_r;
	wire         tx_bt = tick && (sync_m || tx_os_r == OVS_LAST);
	// index of the last slot after start: data, parity, stops
	wire [3:0]   tx_len = nbits + {3'h0, par_on} + {3'h0, sl2};
	wire [8:0]   tx_cur = tx_second_r ? {1'b0, txd_r[15:8]} : txd_r[8:0];
	// slot decode: data first, then parity, then stop bits
	wire         tx_in_data = tx_bit_r < nbits;
	wire         tx_in_par  = par_on && tx_bit_r == nbits;
	wire         tx_last    = tx_bit_r == tx_len;
	// two-frame transmit goes back for the high byte before finishing
	wire         tx_more    = tx2 && !tx_second_r;                    // [R2]

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			tx_st_r     <= DFSP_IDLE;
			txd_r       <= 16'h0000;
			tx_os_r     <= 4'h0;
			tx_bit_r    <= 4'h0;
			tx_second_r <= 1'b0;
			tx_busy_r   <= 1'b0;
			tx_par_r    <= 1'b0;
			tx_out_r    <= 1'b1;                                    // [R26]
			tx_irq_r    <= 1'b0;
		end else begin
			tx_irq_r <= 1'b0;
			if (tick)
				tx_os_r <= (tx_st_r == DFSP_IDLE) ? 4'h0 : tx_os_r + 4'h1;
			case (tx_st_r)
				DFSP_IDLE: begin
					tx_out_r <= 1'b1;
					if (w_txs) begin                                 // [R19]
						txd_r       <= w_low ? {8'h00, WDATA[7:0]} : WDATA;
						tx_busy_r   <= 1'b1;                         // [R7]
						tx_second_r <= 1'b0;
						tx_st_r     <= DFSP_START;
					end
				end
				DFSP_START: if (tx_bt) begin
					tx_out_r <= 1'b0;                                // [R26] [R22]
					tx_bit_r <= 4'h0;
					tx_par_r <= par_bit(tx_cur, nbits, fmt_r);
					tx_st_r  <= DFSP_SHIFT;
				end
				DFSP_SHIFT: if (tx_bt) begin
					if (tx_in_data)
						tx_out_r <= tx_cur[tx_bit_r];                // [R22]
					else if (tx_in_par)
						tx_out_r <= tx_par_r;
					else
						tx_out_r <= 1'b1;                            // [R25]
					tx_bit_r <= tx_bit_r + 4'h1;
					if (tx_last)
						tx_st_r <= DFSP_STOP;
				end
				DFSP_STOP: begin
					if (tx_more) begin                               // [R2]
						tx_second_r <= 1'b1;
						tx_st_r     <= DFSP_START;
					end else begin
						tx_busy_r <= 1'b0;                           // [R7]
						tx_irq_r  <= 1'b1;                           // [R20]
						tx_st_r   <= DFSP_IDLE;
					end
				end
				default: tx_st_r <= DFSP_IDLE;
			endcase
		end
	end

	// ---------------- receiver ----------------
	dfsp_state_t rx_st_r;
	logic [8:0]  rsh_r;
	logic [15:0] rxb_r;
	logic [3:0]  rx_os_r, rx_bit_r;
	logic        rx_busy_r, rx_second_r, rx_par_r, rb8_r;
	logic        pe_r, fe_r, ove_r, unread_r, rx_irq_r;
	wire         rx_bt = tick && (sync_m || rx_os_r == OVS_LAST);
	wire         par_pos = par_on && rx_bit_r == nbits;
	wire         stop_pos = rx_bit_r == nbits + {3'h0, par_on};
	wire         rx_fin = rx_st_r == DFSP_SHIFT && rx_bt && stop_pos;
	wire         pe_now = par_ck && (rx_par_r != par_bit(rsh_r, nbits, fmt_r));  // [R10]
	wire         fe_now = !rx_s2_r;                                  // [R11]
	wire         rx_in_data = rx_bit_r < nbits;
	// an unread buffer is overrun by any frame except the second of a pair
	wire         ov_now = unread_r && !rx_second_r;                  // [R12] [R14]
	// last frame of a complete reception
	wire         last_f = !rx2 || rx_second_r;                       // [R3] [R16]
	// a parity or framing error raises the interrupt at once
	wire         err_now = pe_now || fe_now;                         // [R18]
	// an overrun first frame of a pair stays silent; the next frame ends the pair
	wire         rx_irq_now = last_f || err_now;                     // [R14] [R18]
	wire         rx_second_nxt = rx2 && !rx_second_r;                // [R3]
	wire [15:0]  rx_word = rx_second_r ? {rsh_r[7:0], rxb_r[7:0]} :
		{7'h00, ext ? rsh_r[8] : 1'b0, cl8 | ext ? rsh_r[7] : 1'b0, rsh_r[6:0]};  // [R15]

	always_ff @(posedge CLK) begin
		if (!RST_N || !rxe) begin                                   // [R23] [R17]
			rx_st_r     <= DFSP_IDLE;
			rx_os_r     <= 4'h0;
			rx_bit_r    <= 4'h0;
			rx_busy_r   <= 1'b0;
			rx_second_r <= 1'b0;
			rx_par_r    <= 1'b0;
			rsh_r       <= 9'h000;
			rx_irq_r    <= 1'b0;
		end else begin
			rx_irq_r <= 1'b0;
			if (tick)
				rx_os_r <= rx_os_r + 4'h1;
			case (rx_st_r)
				DFSP_IDLE: if (tick && !rx_s2_r) begin
					rx_os_r <= 4'h0;
					rx_st_r <= sync_m ? DFSP_SHIFT : DFSP_START;     // [R1]
					rx_bit_r <= 4'h0;
					rx_busy_r <= sync_m;
				end
				DFSP_START: if (tick && rx_os_r == OVS_MID) begin
					rx_os_r <= 4'h0;
					if (!rx_s2_r) begin
						rx_busy_r <= 1'b1;                           // [R8]
						rx_st_r   <= DFSP_SHIFT;
					end else
						rx_st_r <= DFSP_IDLE;
				end
				DFSP_SHIFT: if (rx_bt) begin
					if (rx_in_data)
						rsh_r[rx_bit_r] <= rx_s2_r;                  // [R22]
					if (par_pos)
						rx_par_r <= rx_s2_r;
					rx_bit_r <= rx_bit_r + 4'h1;
					if (stop_pos) begin
						rx_busy_r <= 1'b0;                           // [R8]
						// [R3] [R14] [R16] [R18]
						rx_irq_r  <= rx_irq_now;
						rx_second_r <= rx_second_nxt;
						rx_st_r   <= DFSP_STOP;
					end
				end
				DFSP_STOP: if (rx_s2_r || sync_m)
					rx_st_r <= DFSP_IDLE;
				default: rx_st_r <= DFSP_IDLE;
			endcase
		end
	end

	// buffer and flags; a frame arriving with a buffer read wins the flags
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rxb_r    <= 16'h0000;
			rb8_r    <= 1'b0;
			pe_r     <= 1'b0;
			fe_r     <= 1'b0;
			ove_r    <= 1'b0;
			unread_r <= 1'b0;
		end else if (rx_fin && rxe) begin
			rxb_r    <= rx_word;                                     // [R16] [R12]
			rb8_r    <= ext ? rsh_r[8] : 1'b0;                       // [R9]
			pe_r     <= pe_now;                                      // [R13]
			fe_r     <= fe_now;
			ove_r    <= ov_now | (ove_r & ~r_buf);                   // [R14]
			unread_r <= 1'b1;
		end else if (r_buf) begin
			pe_r     <= 1'b0;                                        // [R13]
			fe_r     <= 1'b0;
			ove_r    <= 1'b0;
			unread_r <= 1'b0;
		end
	end

	// status image built field by field; unused bits read zero
	wire [7:0] status = (8'(tx_busy_r) << S_TXB) | (8'(rx_busy_r) << S_RXB) |
		(8'(rb8_r) << S_RB8) | (8'(pe_r) << S_PE) | (8'(fe_r) << S_FE) |
		(8'(ove_r) << S_OVE);                                        // [R7] [R8] [R9]
	// write-only shift register and holes read zero
	wire [15:0] rd_mux =
		hit_rxw  ? rxb_r :
		hit_rxl  ? {8'h00, rxb_r[7:0]} :                              // [R15]
		hit_fmt  ? {8'h00, fmt_r} :
		hit_mode ? {8'h00, mode_r} :
		hit_stat ? {8'h00, status} :
		hit_baud ? baud_r : 16'h0000;

	always_ff @(posedge CLK) begin
		if (!RST_N)
			rdata_r <= 16'h0000;
		else
			rdata_r <= RD ? rd_mux : 16'h0000;
	end

	assign RDATA          = rdata_r;
	assign SERIAL_OUT_PIN = tx_out_r;
	assign RX_DONE_IRQ    = rx_irq_r;
	assign TX_DONE_IRQ    = tx_irq_r;
	// index of highest-priority pending request, rx first
	assign IRQ_PRIORITY   = rx_irq_r ? 2'h1 : (tx_irq_r ? 2'h2 : 2'h0);  // [R21]
endmodule : dfsp_top

// *** test/dfsp_chk_sva.sv ***
// Purpose: port assertions for the serial port
// Assumes: one clock, synchronous reset
// Notes:   receive enable is tracked from format writes
`timescale 1ns/10ps
module dfsp_chk
	import dfsp_pkg::*;
(
	input wire logic                        CLK,
	input wire logic                        RST_N,
	input wire logic [dfsp_pkg::ADDR_W-1:0] ADDR,
	input wire logic [15:0]                 WDATA,
	input wire logic                        WR,
	input wire logic                        RD,
	input wire logic [15:0]                 RDATA,
	input wire logic                        SERIAL_OUT_PIN,
	input wire logic                        RX_DONE_IRQ,
	input wire logic                        TX_DONE_IRQ,
	input wire logic [1:0]                  IRQ_PRIORITY
);
	import dfsp_pkg::*;
	logic rxe_r;
	always_ff @(posedge CLK) begin
		if (!RST_N)
			rxe_r <= 1'b1;
		else if (WR && ADDR == OFS_FORMAT)
			rxe_r <= WDATA[F_RXE];
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	rx_prio_a: assert property (RX_DONE_IRQ |-> IRQ_PRIORITY == 2'h1)
		else $error("rx priority wrong");
	tx_prio_a: assert property (TX_DONE_IRQ && !RX_DONE_IRQ |-> IRQ_PRIORITY == 2'h2)
		else $error("tx priority wrong");
	no_prio_a: assert property (!RX_DONE_IRQ && !TX_DONE_IRQ |-> IRQ_PRIORITY == 2'h0)
		else $error("priority without request");
	rx_off_a: assert property (!rxe_r |-> !RX_DONE_IRQ)
		else $error("rx irq while disabled");
	rx_pulse_a: assert property (RX_DONE_IRQ |=> !RX_DONE_IRQ)
		else $error("rx irq too long");
	tx_pulse_a: assert property (TX_DONE_IRQ |=> !TX_DONE_IRQ)
		else $error("tx irq too long");
	tx_idle_a: assert property (TX_DONE_IRQ |-> SERIAL_OUT_PIN)
		else $error("line low at tx end");
	err_clear_a: assert property ((RD && ADDR == OFS_RXB_WORD) ##2
		(RD && ADDR == OFS_STATUS) |=> RDATA[2:0] == 3'h0)
		else $error("errors not cleared");
endmodule : dfsp_chk

// *** test/dfsp_remote.sv ***
// Purpose: remote serial station on the far side of the line
// Assumes: one bit lasts BIT clocks
// Notes:   captured frames hold the stop level in bit 10
`timescale 1ns/10ps
module dfsp_remote #(
	parameter int BIT = 16
) (
	input  wire logic CLK,
	input  wire logic line_in,
	output logic      line_out
);
	int         rx_bits = 8;
	logic [10:0] got_q[$];
	logic [9:0]  v;
	initial line_out = 1'b1;
	task automatic send(input logic [9:0] d, input int n, input logic stp);
		@(posedge CLK);
		line_out <= 1'b0;
		repeat (BIT) @(posedge CLK);
		for (int i = 0; i < n; i++) begin
			line_out <= d[i];
			repeat (BIT) @(posedge CLK);
		end
		line_out <= stp;
		repeat (BIT) @(posedge CLK);
		line_out <= 1'b1;
		repeat (2 * BIT) @(posedge CLK);
	endtask : send
	// samples mid bit, lsb first
	always begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge CLK);
		if (!line_in) begin
			v = 10'h000;
			for (int i = 0; i < rx_bits; i++) begin
				repeat (BIT) @(posedge CLK);
				v[i] = line_in;
			end
			repeat (BIT) @(posedge CLK);
			got_q.push_back({line_in, v});
		end
	end
endmodule : dfsp_remote

// *** test/tb_top.sv ***
// Purpose: register and line scenarios for the serial port
// Assumes: baud divider 0, one tick per clock, until the sync case sets 15
// Notes:   irq pulses are counted continuously
`timescale 1ns/10ps
module tb_top;
	import dfsp_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [15:0] wdata = 16'h0;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic [15:0] rdata;
	logic        sin, sout, rxi, txi;
	logic [1:0]  prio;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          n_rx = 0;
	int          n_tx = 0;
	int          erx = 0;
	int          cyc = 0;
	always #20 clk = ~clk;
	dfsp_top uut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
		.RD(rd_s), .RDATA(rdata), .SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN(sout),
		.RX_DONE_IRQ(rxi), .TX_DONE_IRQ(txi), .IRQ_PRIORITY(prio));
	dfsp_remote far (.CLK(clk), .line_in(sout), .line_out(sin));
	always @(posedge clk) begin
		cyc++;
		if (rxi === 1'b1) n_rx++;
		if (txi === 1'b1) n_tx++;
		if (cyc == 40000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("[FAIL] %s exp %h got %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rc(input logic [31:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk($sformatf("reg %h", a), e, rdata);
	endtask : rc
	task automatic rxf(input logic [9:0] d, input int n, input logic s, input int k);
		far.send(d, n, s);
		erx += k;
		chk("rx irqs", 16'(erx), 16'(n_rx));
	endtask : rxf
	task automatic wtx(input int k);
		for (int i = 0; i < 2000 && n_tx < k; i++) @(posedge clk);
		chk("tx irqs", 16'(k), 16'(n_tx));
	endtask : wtx
	task automatic chkq(input logic [10:0] e);
		for (int i = 0; i < 400 && far.got_q.size() == 0; i++) @(posedge clk);
		chk("line frame", {5'h00, e}, {5'h00, far.got_q.pop_front()});
	endtask : chkq
	task automatic give_verdict();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rc(OFS_MODE, 16'h0000);
		rc(OFS_STATUS, 16'h0000);
		rc(OFS_FORMAT, 16'h0081);
		rc(32'h00000000, 16'h0000);
		wr(OFS_BAUD, 16'h0000);
		wr(OFS_FORMAT, 16'h00C8);
		wr(OFS_TXS_LOW, 16'h00A5);
		rc(OFS_STATUS, 16'h0080);
		wtx(1);
		rc(OFS_STATUS, 16'h0000);
		chkq(11'h4A5);
		rxf(10'h03C, 8, 1'b1, 1);
		rc(OFS_STATUS, 16'h0000);
		rc(OFS_RXB_WORD, 16'h003C);
		rxf(10'h011, 8, 1'b1, 1);
		rxf(10'h022, 8, 1'b1, 1);
		rc(OFS_STATUS, 16'h0001);
		rc(OFS_RXB_WORD, 16'h0022);
		rc(OFS_STATUS, 16'h0000);
		rxf(10'h05A, 8, 1'b0, 1);
		rc(OFS_STATUS, 16'h0002);
		rc(OFS_RXB_LOW, 16'h005A);
		rc(OFS_STATUS, 16'h0000);
		wr(OFS_FORMAT, 16'h00F8);
		rxf(10'h13C, 9, 1'b1, 1);
		rc(OFS_STATUS, 16'h0004);
		rc(OFS_RXB_WORD, 16'h003C);
		wr(OFS_FORMAT, 16'h00D8);
		rxf(10'h13C, 9, 1'b1, 1);
		rc(OFS_STATUS, 16'h0000);
		rc(OFS_RXB_WORD, 16'h003C);
		wr(OFS_FORMAT, 16'h00C0);
		rxf(10'h07F, 7, 1'b1, 1);
		rc(OFS_RXB_LOW, 16'h007F);
		wr(OFS_FORMAT, 16'h0088);
		rxf(10'h066, 8, 1'b1, 0);
		wr(OFS_FORMAT, 16'h00C8);
		rc(OFS_RXB_WORD, 16'h007F);
		wr(OFS_MODE, 16'h0002);
		rxf(10'h034, 8, 1'b1, 0);
		rxf(10'h012, 8, 1'b1, 1);
		rc(OFS_RXB_WORD, 16'h1234);
		rxf(10'h056, 8, 1'b1, 0);
		rxf(10'h078, 8, 1'b1, 1);
		rxf(10'h09A, 8, 1'b1, 0);
		rxf(10'h0BC, 8, 1'b1, 1);
		rc(OFS_STATUS, 16'h0001);
		rc(OFS_RXB_WORD, 16'hBC9A);
		wr(OFS_MODE, 16'h0005);
		wr(OFS_TXS_WORD, 16'hBEEF);
		wtx(2);
		chkq(11'h4EF);
		chkq(11'h4BE);
		wr(OFS_MODE, 16'h0001);
		far.rx_bits = 9;
		wr(OFS_TXS_WORD, 16'h01A5);
		wtx(3);
		chkq(11'h5A5);
		rxf(10'h155, 9, 1'b1, 1);
		rc(OFS_STATUS, 16'h0010);
		rc(OFS_RXB_WORD, 16'h0155);
		wr(OFS_BAUD, 16'h000F);
		wr(OFS_MODE, 16'h0008);
		far.rx_bits = 8;
		wr(OFS_TXS_LOW, 16'h005A);
		wtx(4);
		chkq(11'h45A);
		give_verdict();
	end
endmodule : tb_top
bind dfsp_top dfsp_chk chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
	.RX_DONE_IRQ(RX_DONE_IRQ), .TX_DONE_IRQ(TX_DONE_IRQ), .IRQ_PRIORITY(IRQ_PRIORITY));
